// ==== design/adc_port_pkg.sv ====
package adc_port_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int CONV_TIME_US = 55;
  localparam int REQ_LIMIT_US = 100;
  localparam int RESULT_BITS = 11;
  localparam int BIT_TIME_NS = (CONV_TIME_US * 1000) / RESULT_BITS;
  localparam int BIT_CYCLES =
    (BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int REQ_LIMIT_CYCLES_DEF =
    (REQ_LIMIT_US * 1000) / CLOCK_PERIOD_NS;
  localparam int DIV_BITS = 8;
  localparam int WAIT_BITS = 13;

  // ---------------------------------------------------------------
  // Result layout and channel map
  // ---------------------------------------------------------------
  localparam int SIGN_POS = 10;
  localparam int TOP_LSB = 8;
  localparam int CHAN_SEL_BITS = 3;
  localparam int CHAN_COUNT = 1 << CHAN_SEL_BITS;
  localparam int CHAN_MAX_BITS = 4;
  localparam logic [15:0] CHAN_BASE = 16'h2080;
  localparam logic [15:0] RAM_BASE = 16'h2100;
  localparam int RAM_ADDR_BITS = 7;
  localparam int RAM_DEPTH = 128;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [10:0] RESULT_RESET = 11'h000;
  localparam logic [10:0] FIRST_TRIAL = 11'h400;
  localparam logic [3:0] IDX_RESET = 4'ha;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT_HI, BUS_WAIT_LO}
    bus_state_t;
  typedef enum logic [1:0] {STORE_IDLE, STORE_HI, STORE_LO} store_state_t;
  typedef enum logic {SAR_IDLE, SAR_RUN} sar_state_t;

  // Upper byte: zero above the sign and the two top magnitude bits
  function automatic logic [7:0] hi_byte(input logic [10:0] code);
    hi_byte = {5'h00, code[SIGN_POS:TOP_LSB]};
  endfunction : hi_byte

  function automatic logic [7:0] lo_byte(input logic [10:0] code);
    lo_byte = code[TOP_LSB-1:0];
  endfunction : lo_byte

  // Copy of channel c sits at 2c (upper byte) and 2c+1 (lower byte)
  function automatic logic [RAM_ADDR_BITS-1:0] slot_addr(
    input logic [CHAN_SEL_BITS-1:0] chan, input logic low);
    slot_addr = RAM_ADDR_BITS'({chan, low});
  endfunction : slot_addr

endpackage : adc_port_pkg

// ==== design/sar_converter.sv ====
`timescale 1ns/1ps
module sar_converter
  import adc_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic top_ready,
  output logic done,
  // Analog side
  input wire logic comp_in,
  output logic [10:0] code
);

  logic [DIV_BITS-1:0] div_q;
  logic pend_q;
  sar_state_t state_q;
  logic [3:0] idx_q;
  logic [10:0] code_q;
  logic done_q;
  logic bit_tick;
  logic [10:0] trial_mask;
  logic [10:0] code_next;
  logic last_bit;

  // ---------------------------------------------------------------
  // Converter clock: free running, unrelated to bus accesses
  // ---------------------------------------------------------------
  assign bit_tick = (div_q == DIV_BITS'(BIT_CYCLES - 1));
  assign trial_mask = 11'h001 << idx_q;
  assign code_next = (comp_in ? code_q : (code_q & ~trial_mask))
    | (trial_mask >> 1);
  assign last_bit = (idx_q == 4'h0);

  always_ff @(posedge clock)
  begin
    if (rst || bit_tick)
      div_q <= '0;
    else
      div_q <= div_q + DIV_BITS'(1);
  end

  // ---------------------------------------------------------------
  // Successive approximation, one bit per converter tick
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      state_q <= SAR_IDLE;
      idx_q <= IDX_RESET;
      code_q <= RESULT_RESET;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
        pend_q <= 1'b1;
      if (bit_tick && pend_q && !start)
      begin
        pend_q <= 1'b0;
        state_q <= SAR_RUN;
        idx_q <= IDX_RESET;
        code_q <= FIRST_TRIAL;
      end
      else if (bit_tick && state_q == SAR_RUN && !pend_q)
      begin
        code_q <= code_next;
        idx_q <= idx_q - 4'h1;
        if (last_bit)
        begin
          state_q <= SAR_IDLE;
          // A restart in this cycle would file the old code under the
          // new channel, so the finished result is dropped instead
          done_q <= !start;
        end
      end
    end
  end

  assign busy = pend_q || (state_q == SAR_RUN);
  assign top_ready = (state_q == SAR_RUN) && !pend_q
    && (idx_q < 4'(TOP_LSB));
  assign done = done_q;
  assign code = code_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [WAIT_BITS-1:0] run_cnt_q;
  always_ff @(posedge clock)
  begin
    if (rst || start)
      run_cnt_q <= '0;
    else if (busy)
      run_cnt_q <= run_cnt_q + WAIT_BITS'(1);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_CONV_LENGTH: assert property (
    done |-> (run_cnt_q >= WAIT_BITS'(RESULT_BITS * BIT_CYCLES))
      && (run_cnt_q <= WAIT_BITS'((RESULT_BITS + 2) * BIT_CYCLES)))
    else $error("conversion length outside expected window");
  AST_TOP_STABLE: assert property (
    top_ready && !start |=> $stable(code_q[SIGN_POS:TOP_LSB]))
    else $error("top result bits changed after release");
  AST_STEP_ON_TICK: assert property (
    (state_q == SAR_RUN) && !bit_tick |=> $stable(code_q))
    else $error("approximation stepped without converter tick");
  COV_DONE: cover property (done);

endmodule : sar_converter

// ==== design/card_ram.sv ====
`timescale 1ns/1ps
module card_ram
  import adc_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [RAM_ADDR_BITS-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [RAM_ADDR_BITS-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_q [RAM_DEPTH];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < RAM_DEPTH; i++)
        mem_q[i] <= BYTE_RESET;
    end
    else if (wr_en)
      mem_q[wr_addr] <= wr_data;
  end

  assign rd_data = mem_q[rd_addr];

endmodule : card_ram

// ==== design/adc_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Even channel address read selects input, starts conversion
// - Finished value returned on data bus
// - Eight channels, select field widens to sixteen
// - Value available under 100 us
// - Eleven-bit signed successive approximation result
// - Result split over two byte reads
// - Top bits returned while low bits resolve
// - Eight low bits returned as one byte
// - Both bytes also copied into card RAM
// - Converter timing independent, crossing synchronised
// - Channels on pairs from 2080, RAM apart
// - Decode read, latch multiplexer, pulse start
// - Conversion completes about 55 us after start
module adc_port
  import adc_port_pkg::*;
#(
  parameter int REQ_LIMIT_CYCLES = REQ_LIMIT_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor bus
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic bus_ack,
  output logic [7:0] bus_rdata,
  // Analog front end
  input wire logic comp_in,
  output logic [10:0] dac_code,
  output logic [CHAN_MAX_BITS-1:0] mux_sel,
  output logic soc,
  output logic conv_busy
);

  bus_state_t bus_state_q;
  bus_state_t bus_state_d;
  store_state_t store_q;
  store_state_t store_d;
  logic bus_ack_q;
  logic [7:0] bus_rdata_q;
  logic [7:0] bus_rdata_d;
  logic soc_q;
  logic [CHAN_SEL_BITS-1:0] conv_chan_q;
  logic [10:0] result_q;
  logic [CHAN_SEL_BITS-1:0] result_chan_q;
  logic result_valid_q;
  logic sar_busy;
  logic sar_top;
  logic sar_done;
  logic [10:0] sar_code;
  logic [7:0] ram_rd;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic chan_hit;
  logic ram_hit;
  logic odd_addr;
  logic [CHAN_SEL_BITS-1:0] addr_chan;
  logic take;
  logic write_blocked;
  logic take_ok;
  logic chan_rd;
  logic start_conv;
  logic lo_wait;
  logic use_result;
  logic ram_bus_we;
  logic hi_answer;
  logic lo_answer;
  logic ack_d;

  assign chan_hit = bus_addr[15:CHAN_SEL_BITS+1]
    == CHAN_BASE[15:CHAN_SEL_BITS+1];
  assign ram_hit = bus_addr[15:RAM_ADDR_BITS]
    == RAM_BASE[15:RAM_ADDR_BITS];
  assign odd_addr = bus_addr[0];
  assign addr_chan = bus_addr[CHAN_SEL_BITS:1];
  // Ack of the previous access is still visible for one cycle
  assign take = (bus_state_q == BUS_IDLE) && bus_req && !bus_ack_q;
  // RAM writes wait while a finished result is being copied
  assign write_blocked = ram_hit && bus_wr && (store_q != STORE_IDLE);
  assign take_ok = take && !write_blocked;
  assign chan_rd = take_ok && chan_hit && !bus_wr;
  assign start_conv = chan_rd && !odd_addr;
  assign lo_wait = chan_rd && odd_addr && sar_busy
    && (addr_chan == conv_chan_q);
  assign use_result = result_valid_q && (addr_chan == result_chan_q);
  assign ram_bus_we = take_ok && ram_hit && bus_wr;
  assign hi_answer = (bus_state_q == BUS_WAIT_HI) && sar_top;
  assign lo_answer = (bus_state_q == BUS_WAIT_LO) && !sar_busy;
  assign ack_d = (take_ok && !start_conv && !lo_wait)
    || hi_answer || lo_answer;

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  logic [RAM_ADDR_BITS-1:0] ram_raddr;
  logic [7:0] chan_lo_data;

  assign ram_raddr = (chan_hit && odd_addr) ?
    slot_addr(addr_chan, 1'b1) : bus_addr[RAM_ADDR_BITS-1:0];
  assign chan_lo_data = use_result ? lo_byte(result_q) : ram_rd;
  assign bus_rdata_d =
    hi_answer ? hi_byte(sar_code) :
    lo_answer ? lo_byte(sar_code) :
    (chan_rd && odd_addr) ? chan_lo_data :
    (take_ok && ram_hit && !bus_wr) ? ram_rd :
    BYTE_RESET;

  // ---------------------------------------------------------------
  // Bus sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    bus_state_d = bus_state_q;
    unique case (bus_state_q)
      BUS_IDLE:
      begin
        if (start_conv)
          bus_state_d = BUS_WAIT_HI;
        else if (lo_wait)
          bus_state_d = BUS_WAIT_LO;
      end
      BUS_WAIT_HI:
      begin
        if (sar_top)
          bus_state_d = BUS_IDLE;
      end
      BUS_WAIT_LO:
      begin
        if (!sar_busy)
          bus_state_d = BUS_IDLE;
      end
      default:
        bus_state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bus_state_q <= BUS_IDLE;
      bus_ack_q <= 1'b0;
      bus_rdata_q <= BYTE_RESET;
      soc_q <= 1'b0;
      conv_chan_q <= '0;
    end
    else
    begin
      bus_state_q <= bus_state_d;
      bus_ack_q <= ack_d;
      if (ack_d)
        bus_rdata_q <= bus_rdata_d;
      soc_q <= start_conv;
      if (start_conv)
        conv_chan_q <= addr_chan;
    end
  end

  // ---------------------------------------------------------------
  // Result capture and copy into card RAM
  // ---------------------------------------------------------------
  always_comb
  begin
    store_d = store_q;
    unique case (store_q)
      STORE_IDLE:
      begin
        if (sar_done)
          store_d = STORE_HI;
      end
      STORE_HI:
        store_d = STORE_LO;
      STORE_LO:
        store_d = STORE_IDLE;
      default:
        store_d = STORE_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      store_q <= STORE_IDLE;
      result_q <= RESULT_RESET;
      result_chan_q <= '0;
      result_valid_q <= 1'b0;
    end
    else
    begin
      store_q <= store_d;
      if (sar_done)
      begin
        result_q <= sar_code;
        result_chan_q <= conv_chan_q;
        result_valid_q <= 1'b1;
      end
    end
  end

  logic ram_we;
  logic [RAM_ADDR_BITS-1:0] ram_waddr;
  logic [7:0] ram_wdata;

  assign ram_we = (store_q != STORE_IDLE) || ram_bus_we;
  assign ram_waddr =
    (store_q == STORE_HI) ? slot_addr(result_chan_q, 1'b0) :
    (store_q == STORE_LO) ? slot_addr(result_chan_q, 1'b1) :
    bus_addr[RAM_ADDR_BITS-1:0];
  assign ram_wdata =
    (store_q == STORE_HI) ? hi_byte(result_q) :
    (store_q == STORE_LO) ? lo_byte(result_q) :
    bus_wdata;

  // ---------------------------------------------------------------
  // Converter and RAM
  // ---------------------------------------------------------------
  sar_converter u_sar (
    .clock(clock),
    .rst(rst),
    .start(start_conv),
    .busy(sar_busy),
    .top_ready(sar_top),
    .done(sar_done),
    .comp_in(comp_in),
    .code(sar_code)
  );

  card_ram u_ram (
    .clock(clock),
    .rst(rst),
    .wr_en(ram_we),
    .wr_addr(ram_waddr),
    .wr_data(ram_wdata),
    .rd_addr(ram_raddr),
    .rd_data(ram_rd)
  );

  assign bus_ack = bus_ack_q;
  assign bus_rdata = bus_rdata_q;
  assign dac_code = sar_code;
  assign mux_sel = CHAN_MAX_BITS'(conv_chan_q);
  assign soc = soc_q;
  assign conv_busy = sar_busy;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [WAIT_BITS-1:0] wait_cnt_q;
  always_ff @(posedge clock)
  begin
    if (rst || start_conv)
      wait_cnt_q <= '0;
    else if (sar_busy)
      wait_cnt_q <= wait_cnt_q + WAIT_BITS'(1);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_START_ON_READ: assert property (
    start_conv |=> soc && sar_busy
      && (mux_sel == CHAN_MAX_BITS'($past(addr_chan))))
    else $error("channel read did not start conversion");
  AST_HI_ZERO_TOP: assert property (
    bus_ack && $past(bus_state_q == BUS_WAIT_HI) |-> bus_rdata[7:3] == 5'h00)
    else $error("first byte upper bits not zero");
  AST_HI_EARLY: assert property (
    bus_ack && $past(bus_state_q == BUS_WAIT_HI) |-> conv_busy
      && bus_rdata[2:0] == $past(dac_code[SIGN_POS:TOP_LSB]))
    else $error("first byte wrong or late");
  AST_LO_HOLD: assert property (
    (bus_state_q == BUS_WAIT_LO) && sar_busy |=> !bus_ack)
    else $error("second byte answered before resolution");
  AST_LO_VALUE: assert property (
    bus_ack && $past(bus_state_q == BUS_WAIT_LO)
      |-> bus_rdata == result_q[7:0])
    else $error("second byte differs from result");
  AST_RAM_COPY: assert property (
    sar_done |=> (ram_we && ram_wdata == hi_byte(result_q))
      ##1 (ram_we && ram_wdata == lo_byte(result_q)))
    else $error("result not copied into card RAM");
  AST_REQ_LIMIT: assert property (
    sar_busy |-> wait_cnt_q < WAIT_BITS'(REQ_LIMIT_CYCLES))
    else $error("conversion exceeded request time limit");
  AST_MUX_HELD: assert property (
    conv_busy && !start_conv |=> $stable(mux_sel))
    else $error("multiplexer select moved during conversion");
  AST_PAIR_ORDER: assert property (
    start_conv |=> !bus_ack [*2])
    else $error("first byte answered without waiting");

  COV_HI_READ: cover property (bus_ack && $past(bus_state_q == BUS_WAIT_HI));
  COV_LO_HOLD: cover property (bus_ack && $past(bus_state_q == BUS_WAIT_LO));
  COV_RAM_WRITE: cover property (ram_bus_we);
  COV_COPY_READ: cover property (chan_rd && odd_addr && !use_result);

endmodule : adc_port

// ==== dv/cpu_bus_model.sv ====
`timescale 1ns/1ps
module cpu_bus_model
(
  // Clock
  input wire logic clock,
  // Request lines
  output logic bus_req,
  output logic bus_wr,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  // Answer lines
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  initial
  begin
    bus_req = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 16'hffff;
    bus_wdata = 8'hff;
  end

  // ---------------------------------------------------------------
  // One byte load or store, held until acknowledged or 8000 cycles pass
  // ---------------------------------------------------------------
  // Released lines show the inverse so a stale value is never reused
  task automatic access(input logic wr, input logic [15:0] addr,
    input logic [7:0] wdata, output logic [7:0] rdata, output int cyc);
    begin
      @(posedge clock);
      bus_req <= 1'b1;
      bus_wr <= wr;
      bus_addr <= addr;
      bus_wdata <= wdata;
      rdata = 8'hxx;
      cyc = 0;
      do
      begin
        @(posedge clock);
        cyc++;
      end while (bus_ack !== 1'b1 && cyc < 8000);
      if (bus_ack === 1'b1)
        rdata = bus_rdata;
      bus_req <= 1'b0;
      bus_wr <= ~wr;
      bus_addr <= ~addr;
      bus_wdata <= ~wdata;
    end
  endtask : access
endmodule : cpu_bus_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module testbench;
  localparam logic [10:0] LEVELS [8] = '{11'h000, 11'h7ff, 11'h400,
    11'h3ff, 11'h2a5, 11'h55a, 11'h123, 11'h6dc};

  logic clock;
  logic rst = 1'b1;
  logic comp_in = 1'b0;
  logic bus_req;
  logic bus_wr;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_ack;
  logic [7:0] bus_rdata;
  logic [10:0] dac_code;
  logic [3:0] mux_sel;
  logic soc;
  logic conv_busy;
  logic [10:0] level [8];
  int error_cnt = 0;
  int n_compared = 0;
  int soc_cnt = 0;
  int run_len = 0;
  int busy_len = 0;

  // ---------------------------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  adc_port adc_port_i (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .comp_in(comp_in),
    .dac_code(dac_code), .mux_sel(mux_sel), .soc(soc),
    .conv_busy(conv_busy));

  cpu_bus_model cpu_bus_model_i (.clock(clock), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  // ---------------------------------------------------------------
  // Analog side and monitors
  // ---------------------------------------------------------------
  // Ideal comparator: the finished code equals the channel level
  always @(posedge clock)
    comp_in <= (level[mux_sel[2:0]] >= dac_code);

  always @(posedge clock)
  begin
    if (soc === 1'b1)
      soc_cnt++;
    if (conv_busy === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      busy_len = run_len;
      run_len = 0;
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    begin
      if (error_cnt == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask : tally_and_finish

  task automatic check_reset();
    begin
      `CHECK(bus_rdata, 8'h00)
      `CHECK(bus_ack, 1'b0)
      `CHECK(soc, 1'b0)
      `CHECK(mux_sel, 4'h0)
      `CHECK(dac_code, 11'h000)
      `CHECK(conv_busy, 1'b0)
    end
  endtask : check_reset

  task automatic convert_pair(input int c, input logic [10:0] v);
    logic [7:0] rd;
    int cyc_e;
    int cyc_o;
    int socs;
    begin
      level[c] = v;
      socs = soc_cnt;
      cpu_bus_model_i.access(1'b0, 16'h2080 + 16'(2 * c), 8'h00, rd, cyc_e);
      @(negedge clock);
      `CHECK(rd, {5'h00, v[10:8]})
      `CHECK(conv_busy, 1'b1)
      `CHECK(mux_sel, 4'(c))
      `CHECK(soc_cnt - socs, 1)
      cpu_bus_model_i.access(1'b0, 16'h2081 + 16'(2 * c), 8'h00, rd, cyc_o);
      @(negedge clock);
      `CHECK(rd, v[7:0])
      `CHECK(conv_busy, 1'b0)
      `CHECK(cyc_e + cyc_o < 5000, 1'b1)
      `CHECK(busy_len > 2700 && busy_len < 3100, 1'b1)
      cpu_bus_model_i.access(1'b0, 16'h2100 + 16'(2 * c), 8'h00, rd, cyc_o);
      `CHECK(rd, {5'h00, v[10:8]})
      cpu_bus_model_i.access(1'b0, 16'h2101 + 16'(2 * c), 8'h00, rd, cyc_o);
      `CHECK(rd, v[7:0])
    end
  endtask : convert_pair

  task automatic misc_access();
    logic [7:0] rd;
    int cyc;
    int socs;
    begin
      socs = soc_cnt;
      cpu_bus_model_i.access(1'b1, 16'h217f, 8'h5a, rd, cyc);
      cpu_bus_model_i.access(1'b0, 16'h217f, 8'h00, rd, cyc);
      `CHECK(rd, 8'h5a)
      cpu_bus_model_i.access(1'b1, 16'h2083, 8'hc3, rd, cyc);
      cpu_bus_model_i.access(1'b0, 16'h2083, 8'h00, rd, cyc);
      `CHECK(rd, LEVELS[1][7:0])
      cpu_bus_model_i.access(1'b0, 16'h208f, 8'h00, rd, cyc);
      `CHECK(rd, LEVELS[7][7:0])
      cpu_bus_model_i.access(1'b0, 16'h2180, 8'h00, rd, cyc);
      `CHECK(rd, 8'h00)
      @(negedge clock);
      `CHECK(soc_cnt - socs, 0)
    end
  endtask : misc_access

  // A second even read in a row restarts on the new channel
  task automatic restart_conv();
    logic [7:0] rd;
    int cyc;
    int socs;
    begin
      level[2] = 11'h1e1;
      level[3] = 11'h61e;
      socs = soc_cnt;
      cpu_bus_model_i.access(1'b0, 16'h2084, 8'h00, rd, cyc);
      cpu_bus_model_i.access(1'b0, 16'h2086, 8'h00, rd, cyc);
      `CHECK(rd, 8'h06)
      cpu_bus_model_i.access(1'b0, 16'h2087, 8'h00, rd, cyc);
      @(negedge clock);
      `CHECK(rd, 8'h1e)
      `CHECK(mux_sel, 4'h3)
      `CHECK(soc_cnt - socs, 2)
    end
  endtask : restart_conv

  // A reset after the last conversion clears the outputs and the card RAM
  task automatic reset_mid();
    logic [7:0] rd;
    int cyc;
    begin
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      check_reset();
      cpu_bus_model_i.access(1'b0, 16'h217f, 8'h00, rd, cyc);
      `CHECK(rd, 8'h00)
    end
  endtask : reset_mid

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    foreach (level[i])
      level[i] = 11'h000;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check_reset();
    for (int c = 0; c < 8; c++)
      convert_pair(c, LEVELS[c]);
    misc_access();
    restart_conv();
    reset_mid();
    tally_and_finish();
  end

  // About 27000 cycles are expected; nearly three times that means a hang
  initial
  begin
    #1500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : testbench
